// *** verilog/wdt_pkg.sv ***
// Purpose: Shared constants for the 16-bit watchdog / general timer
// Assumes: 32-bit byte-addressed register port, 40 MHz mclk
// Notes:   Register addresses are the full byte addresses
`default_nettype none
package wdt_pkg;
  // Register map
  localparam logic [31:0] WDT_RELOAD_ADDR = 32'hffff0360;
  localparam logic [31:0] WDT_COUNT_ADDR  = 32'hffff0364;
  localparam logic [31:0] WDT_CTRL_ADDR   = 32'hffff0368;
  localparam logic [31:0] WDT_CLEAR_ADDR  = 32'hffff036c;

  // Reset values
  localparam logic [15:0] WDT_RELOAD_RST  = 16'h0040;
  localparam logic [15:0] WDT_COUNT_RST   = 16'h0040;
  localparam logic [15:0] WDT_CTRL_RST    = 16'h0000;
  // Writable control bits: 8..5, 3..0
  localparam logic [15:0] WDT_CTRL_WMASK  = 16'h01ef;
  localparam logic [15:0] WDT_COUNT_FULL  = 16'hffff;

  // Control field positions
  localparam int WDT_CB_PDHALT    = 0;
  localparam int WDT_CB_IRQSEL    = 1;
  localparam int WDT_CB_PRESC_LSB = 2;
  localparam int WDT_CB_PRESC_MSB = 3;
  localparam int WDT_CB_WDMODE    = 5;
  localparam int WDT_CB_PERIODIC  = 6;
  localparam int WDT_CB_ENABLE    = 7;
  localparam int WDT_CB_UP        = 8;

  // Prescaler codes
  localparam logic [1:0] WDT_PRESC_DIV1   = 2'b00;
  localparam logic [1:0] WDT_PRESC_DIV16  = 2'b01;
  localparam logic [1:0] WDT_PRESC_DIV256 = 2'b10;

  // Timing figures
  localparam int WDT_MCLK_HZ          = 40000000;
  localparam int WDT_LP_OSC_HZ        = 32768;
  localparam int WDT_MAX_TIMEOUT_S    = 512;
  localparam int WDT_MIN_TIMEOUT_MS   = 30;
  // Smallest safe reload at divide-by-1, rounded up
  localparam int WDT_MIN_TIMEOUT_TICKS =
    (WDT_MIN_TIMEOUT_MS * WDT_LP_OSC_HZ + 999) / 1000;
endpackage
`default_nettype wire

// *** verilog/wdt_tick_if.sv ***
// Purpose: Carries oscillator edges and prescale setting to the prescaler
// Assumes: Single mclk domain
// Notes:   tick is combinational from the prescaler
`timescale 1ns/100ps
`default_nettype none
interface wdt_tick_if;
  logic       lp_edge;
  logic [1:0] presc_sel;
  logic       run;
  logic       tick;

  modport src
  (
    input  lp_edge,
    input  presc_sel,
    input  run,
    output tick
  );
  modport user
  (
    output lp_edge,
    output presc_sel,
    output run,
    input  tick
  );
endinterface
`default_nettype wire

// *** verilog/wdt_prescaler.sv ***
// Purpose: Divides synchronised low-power oscillator edges by 1, 16 or 256
// Assumes: lp_edge is a one-cycle mclk pulse
// Notes:   Divider holds while run is low, so a pause does not shorten a period
`timescale 1ns/100ps
`default_nettype none
module wdt_prescaler
(
  input wire logic mclk,
  input wire logic sys_rst,
  wdt_tick_if.src  tk
);
  import wdt_pkg::*;

  logic [7:0] div_reg;
  logic       lp_step;

  assign lp_step = tk.run & tk.lp_edge;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      div_reg <= 8'h00;
    else if (lp_step)
      div_reg <= div_reg + 8'h01;
  end

  always_comb
  begin
    unique case (tk.presc_sel)
      WDT_PRESC_DIV1:   tk.tick = lp_step;
      WDT_PRESC_DIV16:  tk.tick = lp_step & (&div_reg[3:0]);
      WDT_PRESC_DIV256: tk.tick = lp_step & (&div_reg);
      // Reserved code: counter stalls
      default:          tk.tick = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// *** verilog/wdt_timer.sv ***
// Purpose: 16-bit timer with normal and watchdog modes on a 32.768 kHz clock
// Assumes: sys_rst is the power-on reset; other resets never reach this block
// Notes:   Register port answers reads one cycle later, never stalls
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Two modes: general timing and watchdog supervision.
// - On overflow the counter loads the reload value.
// - Normal mode ticks from 32.768 kHz oscillator divided by 1, 16, 256.
// - Control bit 5 set enters watchdog mode.
// - Watchdog starts at reload value and decrements per tick to zero.
// - Divide-by-256 with full-scale reload gives the longest timeout.
// - At zero, reset or interrupt as chosen by control bit 1.
// - Any write to clear register reloads the counter before zero.
// - Watchdog mode locks reload and control registers until power-on reset.
// - Non-power-on resets leave the watchdog running and configured.
// - Counter pauses while the debugger holds the core.
// - Runs in power-down by default; control bit 0 stops it.
// - Reload and count are 16-bit unsigned; count is read-only.
// - Normal mode clear-register write clears the pending interrupt.
// - Reload and count read 0x0040 after reset.
// - Bit 1 set gives interrupt on expiry; clear gives reset.
// - Prescale code 00 div 1, 01 div 16, 10 div 256, 11 reserved.
// - Bit 7 enables counting; bit 6 periodic, else free-running, in down count only.
// - Bit 8 selects up count when set, down when clear.
module wdt_timer
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        lp_osc_clk,
  input  wire logic        debug_halt,
  input  wire logic        periph_powerdown,
  input  wire logic [31:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  output logic             timer_irq,
  output logic             wdt_reset_req
);
  import wdt_pkg::*;

  logic [15:0] reload_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] ctrl_reg;
  logic        irq_reg;
  logic        rst_req_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        lp_meta_reg;
  logic        lp_sync_reg;
  logic        lp_prev_reg;
  logic        dbg_meta_reg;
  logic        dbg_sync_reg;
  logic        wd_mode;
  logic        counting;
  logic        tick;
  logic        wr_reload;
  logic        wr_ctrl;
  logic        wr_clear;
  logic        wd_enter;
  logic        wd_expire;
  logic        up_wrap;
  logic        down_wrap;
  logic        norm_timeout;

  wdt_tick_if tick_if ();

  wdt_prescaler u_presc
  (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .tk      (tick_if.src)
  );

  // Oscillator and debug request come from other domains
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lp_meta_reg <= 1'b0;
      lp_sync_reg <= 1'b0;
      lp_prev_reg <= 1'b0;
    end
    else
    begin
      lp_meta_reg <= lp_osc_clk;
      lp_sync_reg <= lp_meta_reg;
      lp_prev_reg <= lp_sync_reg;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dbg_meta_reg <= 1'b0;
      dbg_sync_reg <= 1'b0;
    end
    else
    begin
      dbg_meta_reg <= debug_halt;
      dbg_sync_reg <= dbg_meta_reg;
    end
  end

  assign wd_mode = ctrl_reg[WDT_CB_WDMODE];

  // Watchdog runs regardless of the enable bit
  assign counting = ~dbg_sync_reg
                  & ~(periph_powerdown & ctrl_reg[WDT_CB_PDHALT])
                  & (wd_mode | ctrl_reg[WDT_CB_ENABLE]);

  assign tick_if.lp_edge   = lp_sync_reg & ~lp_prev_reg;
  assign tick_if.presc_sel = ctrl_reg[WDT_CB_PRESC_MSB:WDT_CB_PRESC_LSB];
  assign tick_if.run       = counting;
  assign tick              = tick_if.tick;

  // Register decode
  assign wr_reload = bus_wr & (bus_addr == WDT_RELOAD_ADDR) & ~wd_mode;
  assign wr_ctrl   = bus_wr & (bus_addr == WDT_CTRL_ADDR) & ~wd_mode;
  assign wr_clear  = bus_wr & (bus_addr == WDT_CLEAR_ADDR);
  assign wd_enter  = wr_ctrl & bus_wdata[WDT_CB_WDMODE];

  // Expiry at the tick that would bring the count to zero
  assign wd_expire    = wd_mode & tick & (count_reg <= 16'h0001);
  assign up_wrap      = count_reg == WDT_COUNT_FULL;
  assign down_wrap    = count_reg == 16'h0000;
  assign norm_timeout = ~wd_mode & tick
                      & (ctrl_reg[WDT_CB_UP] ? up_wrap : down_wrap);

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      reload_reg <= WDT_RELOAD_RST;
    else if (wr_reload)
      reload_reg <= bus_wdata[15:0];
  end

  // Only power-on reset unlocks the control register
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      ctrl_reg <= WDT_CTRL_RST;
    else if (wr_ctrl)
      ctrl_reg <= bus_wdata[15:0] & WDT_CTRL_WMASK;
  end

  always_comb
  begin
    count_next = count_reg;
    if (wd_enter)
      count_next = reload_reg;
    else if (wd_mode & wr_clear)
      count_next = reload_reg;
    else if (wd_mode & tick)
    begin
      if (wd_expire)
        count_next = reload_reg;
      else
        count_next = count_reg - 16'h0001;
    end
    else if (tick)
    begin
      if (ctrl_reg[WDT_CB_UP])
        count_next = up_wrap ? reload_reg : count_reg + 16'h0001;
      else if (down_wrap)
        count_next = ctrl_reg[WDT_CB_PERIODIC] ? reload_reg : WDT_COUNT_FULL;
      else
        count_next = count_reg - 16'h0001;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      count_reg <= WDT_COUNT_RST;
    else
      count_reg <= count_next;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_reg <= 1'b0;
    else if (norm_timeout | (wd_expire & ctrl_reg[WDT_CB_IRQSEL]))
      irq_reg <= 1'b1;
    else if (wr_clear)
      irq_reg <= 1'b0;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      rst_req_reg <= 1'b0;
    else
      rst_req_reg <= wd_expire & ~ctrl_reg[WDT_CB_IRQSEL];
  end

  // Read data valid only in the cycle after the strobe
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (bus_rd)
    begin
      unique case (bus_addr)
        WDT_RELOAD_ADDR: rdata_next = {16'h0000, reload_reg};
        WDT_COUNT_ADDR:  rdata_next = {16'h0000, count_reg};
        WDT_CTRL_ADDR:   rdata_next = {16'h0000, ctrl_reg};
        default:         rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_reg <= 32'h0000_0000;
    else
      rdata_reg <= rdata_next;
  end

  assign bus_rdata     = rdata_reg;
  assign timer_irq     = irq_reg;
  assign wdt_reset_req = rst_req_reg;
endmodule
`default_nettype wire

// *** tb/wdt_timer_asserts.sv ***
// Purpose: Port-level checks for wdt_timer
// Assumes: Single mclk domain, sys_rst is power-on reset
// Notes:   Oscillator-still windows stand in for unseen ticks
`timescale 1ns/100ps
`default_nettype none
module wdt_timer_asserts
  import wdt_pkg::*;
(
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        lp_osc_clk,
  input wire logic        debug_halt,
  input wire logic        periph_powerdown,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic        timer_irq,
  input wire logic        wdt_reset_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire clr_wr = bus_wr && bus_addr == WDT_CLEAR_ADDR;
  a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
    else $error("read data outside its slot");
  a_rdata_upper: assert property (bus_rdata[31:16] == 16'h0)
    else $error("upper read data not zero");
  a_reset_pulse: assert property (wdt_reset_req |=> !wdt_reset_req)
    else $error("reset request longer than one cycle");
  a_irq_sticky: assert property (timer_irq && !clr_wr |=> timer_irq)
    else $error("interrupt dropped without clear");
  a_halt_freeze: assert property (debug_halt [*4] |=> !$rose(timer_irq) && !wdt_reset_req)
    else $error("event while debugger halts");
  a_irq_excl: assert property ($rose(timer_irq) |-> !wdt_reset_req)
    else $error("interrupt and reset together");
  a_osc_still: assert property ($stable(lp_osc_clk) [*6] |=> !$rose(timer_irq) && !wdt_reset_req)
    else $error("event without oscillator edge");
  a_clear_drops: assert property ($stable(lp_osc_clk) [*6] ##0 clr_wr |=> !timer_irq)
    else $error("clear did not drop interrupt");
endmodule
bind wdt_timer wdt_timer_asserts wdt_timer_asserts_inst (.mclk, .sys_rst, .lp_osc_clk,
  .debug_halt, .periph_powerdown, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
  .timer_irq, .wdt_reset_req);
`default_nettype wire

// *** tb/tb_watchdog_timer_16bit.sv ***
// Purpose: Self-checking bench for wdt_timer
// Assumes: Fast oscillator, 13 mclk per period
// Notes:   Runs of 16 and 256 pulses hide divider phase; the last test needs the divider at zero after power-on reset
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_watchdog_timer_16bit;
  import wdt_pkg::*;
  logic        mclk = 0, sys_rst = 1, lp_osc_clk = 0, debug_halt = 0, periph_powerdown = 0;
  logic        bus_wr = 0, bus_rd = 0, timer_irq, wdt_reset_req;
  logic [31:0] bus_addr = 0, bus_wdata = 0, bus_rdata, d;
  int          n_fail = 0, compares = 0, n_rst = 0, seed;
  wdt_timer wdt_timer_inst (.mclk, .sys_rst, .lp_osc_clk, .debug_halt, .periph_powerdown,
    .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .timer_irq, .wdt_reset_req);
  initial forever #12.5 mclk = ~mclk;
  always @(posedge mclk) if (wdt_reset_req === 1'b1) n_rst++;
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge mclk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= v;
    @(posedge mclk);
    bus_wr <= 1'b0;
    #1;
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    @(posedge mclk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1 `CHK(bus_rdata, e)
  endtask
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge mclk) lp_osc_clk <= 1'b1;
      repeat (6) @(posedge mclk);
      lp_osc_clk <= 1'b0;
      repeat (6) @(posedge mclk);
    end
  endtask
  // Periodic down count: zero reloads on the next tick
  function automatic logic [31:0] dn(logic [15:0] c, int n, logic [15:0] r);
    repeat (n) c = (c == 16'h0) ? r : c - 16'h1;
    return {16'h0, c};
  endfunction
  task automatic end_of_test;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #1000000;
    n_fail++;
    end_of_test();
  end
  initial
  begin
    seed = 32'h72e28fb1;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    rdchk(WDT_RELOAD_ADDR, 32'h40);
    rdchk(WDT_COUNT_ADDR, 32'h40);
    rdchk(32'hffff0370, 32'h0);
    wr(WDT_COUNT_ADDR, 32'h1234);
    rdchk(WDT_COUNT_ADDR, 32'h40);
    repeat (4)
    begin
      d = $random(seed);
      wr(WDT_RELOAD_ADDR, d);
      rdchk(WDT_RELOAD_ADDR, {16'h0, d[15:0]});
    end
    wr(WDT_RELOAD_ADDR, 32'h3);
    wr(WDT_CTRL_ADDR, 32'hc0);
    pulse(5);
    rdchk(WDT_COUNT_ADDR, dn(16'h40, 5, 16'h3));
    debug_halt <= 1'b1;
    pulse(3);
    debug_halt <= 1'b0;
    rdchk(WDT_COUNT_ADDR, dn(16'h40, 5, 16'h3));
    @(posedge mclk) periph_powerdown <= 1'b1;
    pulse(2);
    rdchk(WDT_COUNT_ADDR, dn(16'h40, 7, 16'h3));
    wr(WDT_CTRL_ADDR, 32'hc1);
    pulse(2);
    rdchk(WDT_COUNT_ADDR, dn(16'h40, 7, 16'h3));
    @(posedge mclk) periph_powerdown <= 1'b0;
    wr(WDT_CTRL_ADDR, 32'hc0);
    pulse(58);
    `CHK(timer_irq, 1'b1)
    rdchk(WDT_COUNT_ADDR, dn(16'h40, 65, 16'h3));
    wr(WDT_CLEAR_ADDR, $random(seed));
    `CHK(timer_irq, 1'b0)
    wr(WDT_CTRL_ADDR, 32'hc4);
    pulse(16);
    rdchk(WDT_COUNT_ADDR, 32'h2);
    wr(WDT_CTRL_ADDR, 32'hc8);
    pulse(256);
    rdchk(WDT_COUNT_ADDR, 32'h1);
    wr(WDT_CTRL_ADDR, 32'hcc);
    pulse(4);
    rdchk(WDT_COUNT_ADDR, 32'h1);
    wr(WDT_CTRL_ADDR, 32'h1c0);
    pulse(2);
    rdchk(WDT_COUNT_ADDR, 32'h3);
    wr(WDT_CTRL_ADDR, 32'h80);
    pulse(4);
    rdchk(WDT_COUNT_ADDR, 32'hffff);
    wr(WDT_CTRL_ADDR, 32'h180);
    pulse(1);
    rdchk(WDT_COUNT_ADDR, 32'h3);
    wr(WDT_CLEAR_ADDR, 32'h0);
    wr(WDT_RELOAD_ADDR, 32'h5);
    wr(WDT_CTRL_ADDR, 32'h20);
    rdchk(WDT_COUNT_ADDR, 32'h5);
    pulse(3);
    rdchk(WDT_COUNT_ADDR, 32'h2);
    wr(WDT_CLEAR_ADDR, $random(seed));
    rdchk(WDT_COUNT_ADDR, 32'h5);
    wr(WDT_RELOAD_ADDR, 32'h9);
    wr(WDT_CTRL_ADDR, 32'h0);
    rdchk(WDT_RELOAD_ADDR, 32'h5);
    rdchk(WDT_CTRL_ADDR, 32'h20);
    pulse(5);
    `CHK(n_rst, 1)
    rdchk(WDT_COUNT_ADDR, 32'h5);
    // Power-on reset is the only way out of the lock
    @(posedge mclk) sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    rdchk(WDT_CTRL_ADDR, 32'h0);
    // Reload 4 at divide-by-256 keeps the 30 ms floor in scaled time
    wr(WDT_RELOAD_ADDR, 32'h4);
    wr(WDT_CTRL_ADDR, 32'h2a);
    pulse(1023);
    `CHK(timer_irq, 1'b0)
    rdchk(WDT_COUNT_ADDR, 32'h1);
    pulse(1);
    `CHK(timer_irq, 1'b1)
    `CHK(n_rst, 1)
    end_of_test();
  end
endmodule
`default_nettype wire
